// ---- jtp_pkg.sv ----
// Purpose: Shared constants and types of the scan and programming port
// Assumes: Ten-bit instruction register, one flash word per config group
// Notes:   Programming opcodes other than the public scan set are local

package jtp_pkg;

    localparam int IR_W = 10;

    localparam logic [IR_W-1:0] EXTEST_INSTR          = 10'h00f;
    localparam logic [IR_W-1:0] SAMPLE_INSTR          = 10'h005;
    localparam logic [IR_W-1:0] BYPASS_INSTR          = 10'h3ff;
    localparam logic [IR_W-1:0] USERCODE_INSTR        = 10'h007;
    localparam logic [IR_W-1:0] IDCODE_INSTR          = 10'h006;
    localparam logic [IR_W-1:0] HIGHZ_INSTR           = 10'h00b;
    localparam logic [IR_W-1:0] CLAMP_INSTR           = 10'h00a;
    localparam logic [IR_W-1:0] USER_CHAIN_ZERO_INSTR = 10'h00c;
    localparam logic [IR_W-1:0] USER_CHAIN_ONE_INSTR  = 10'h00e;
    localparam logic [IR_W-1:0] ISC_ENABLE_INSTR      = 10'h2cc;
    localparam logic [IR_W-1:0] ISC_PROGRAM_INSTR     = 10'h2f4;
    localparam logic [IR_W-1:0] ISC_DISABLE_INSTR     = 10'h201;
    localparam logic [IR_W-1:0] IR_CAPTURE            = 10'h001;

    localparam int ID_W      = 32;
    localparam int ID_VER_W  = 4;
    localparam int ID_PART_W = 16;
    localparam int ID_MFR_W  = 11;

    localparam int              USERCODE_W     = 32;
    localparam logic [USERCODE_W-1:0] USERCODE_RESET = 32'hffffffff;

    localparam int BSR_LEN_A    = 240;
    localparam int BSR_LEN_B    = 480;
    localparam int BSR_LEN_C    = 636;
    localparam int BSR_LEN_D    = 816;
    localparam int CELLS_PER_IO = 3;
    localparam int CELL_IN      = 0;
    localparam int CELL_OUT     = 1;
    localparam int CELL_OE      = 2;

    localparam int                CFG_AW     = 6;
    localparam int                CFG_DW     = 16;
    localparam int                ISC_W      = CFG_AW + CFG_DW;
    localparam logic [CFG_AW-1:0] DONE_ADDR  = 6'h3f;
    localparam int                DONE_BIT   = 0;
    localparam logic [CFG_DW-1:0] FLASH_INIT = 16'h0000;

    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE,
        TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR, TS_EX2_DR, TS_UPD_DR,
        TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } jtp_tap_state_t;

endpackage

// ---- jtp_configuration_flash_array.sv ----
// Purpose: Non-volatile configuration word store
// Assumes: One write and one read port on the system clock
// Notes:   Read data come out of a register one cycle after the address

`timescale 1ns/1ps

module jtp_configuration_flash_array #(
    parameter int               AW   = 6,
    parameter int               DW   = 16,
    parameter logic [DW-1:0]    INIT = '0
) (
    input  wire logic            i_clk_sys,
    input  wire logic            i_we,
    input  wire logic [AW-1:0]   i_waddr,
    input  wire logic [DW-1:0]   i_wdata,
    input  wire logic [AW-1:0]   i_raddr,
    output logic      [DW-1:0]   o_rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: INIT};

    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule // jtp_configuration_flash_array

// ---- jtp_tap_isp.sv ----
// Purpose: Scan access port with user chains and flash programming control
// Assumes: Tester logic on i_tck; core and flash logic on i_clk_sys
// Notes:   Pin control words cross as quasi-static levels

`timescale 1ns/1ps

// Contract
// - Ten-bit instruction register shifted in
// - Thirty-two bit user-code register between TDI, TDO
// - Boundary length per variant: 240/480/636/816
// - ID: version, part, maker, final bit
// - ID bit zero always one
// - User chains see TAP state, port signals
// - User chains route TDI through array logic
// - Each user instruction owns separate chain
// - Programming tristates pins with pull-ups
// - No pin drives until completion bit set
// - Programming writes pattern into config flash
// - Power-up loads config from flash first
// - Programming instructions follow in-system config standard
// - Flash programming supply generated internally
// - User chain opcodes 0x00c and 0x00e
// - All-ones opcode selects one-bit bypass
// - ID 0x006, user-code 0x007, default ones
// - High-Z 0x00b, clamp 0x00a, external test 0x00f
module jtp_tap_isp
    import jtp_pkg::*;
#(
    parameter int                    BSR_LEN    = BSR_LEN_A,
    parameter logic [ID_VER_W-1:0]   ID_VERSION = 4'h0,
    parameter logic [ID_PART_W-1:0]  ID_PART    = 16'h5a5a,  // Arbitrary value
    parameter logic [ID_MFR_W-1:0]   ID_MFR     = 11'h2aa,   // Arbitrary value
    parameter logic [USERCODE_W-1:0] USERCODE   = USERCODE_RESET,
    localparam int                   N_IO       = BSR_LEN / CELLS_PER_IO
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire logic                i_tck,
    input  wire logic                i_tms,
    input  wire logic                i_tdi,
    output logic                     o_tdo,
    output logic                     o_tdo_oe,
    output jtp_tap_state_t           o_usr_state,
    output logic                     o_usr_tms,
    output logic                     o_usr_tdi,
    output logic                     o_chain0_sel,
    output logic                     o_chain1_sel,
    input  wire logic                i_chain0_tdo,
    input  wire logic                i_chain1_tdo,
    input  wire logic [N_IO-1:0]     i_io_in,
    output logic      [N_IO-1:0]     o_io_out,
    output logic      [N_IO-1:0]     o_io_oe,
    output logic      [N_IO-1:0]     o_io_pullup,
    input  wire logic [N_IO-1:0]     i_core_out,
    input  wire logic [N_IO-1:0]     i_core_oe,
    input  wire logic [N_IO-1:0]     i_core_pullup,
    output logic                     o_cfg_we,
    output logic      [CFG_AW-1:0]   o_cfg_addr,
    output logic      [CFG_DW-1:0]   o_cfg_data,
    output logic                     o_config_done,
    output logic                     o_hv_pump_en
);

    generate
        if (!(BSR_LEN == BSR_LEN_A || BSR_LEN == BSR_LEN_B ||
              BSR_LEN == BSR_LEN_C || BSR_LEN == BSR_LEN_D)) begin : g_bad_len
            $error("Unsupported boundary-scan length");
        end
    endgenerate

    // ---------------- Link clock domain ----------------
    logic                  rst_t1, rst_t2;
    jtp_tap_state_t        state, next_state;
    logic [IR_W-1:0]       ir_sh, next_ir_sh, ir, next_ir;
    logic                  byp, next_byp;
    logic [ID_W-1:0]       word_sh, next_word_sh;
    logic [ISC_W-1:0]      isc_sh, next_isc_sh;
    logic [BSR_LEN-1:0]    bsr_sh, next_bsr_sh, bsr_upd, next_bsr_upd;
    logic [BSR_LEN-1:0]    cap_raw, cap_s1, cap_s2;
    logic [CFG_AW-1:0]     wr_addr, next_wr_addr;
    logic [CFG_DW-1:0]     wr_data, next_wr_data;
    logic                  wr_tgl, next_wr_tgl, isp_req, next_isp_req;
    logic                  mode_highz, next_mode_highz, mode_hold, next_mode_hold;
    logic                  next_tdo, next_tdo_oe, sel_dr_tdo;
    logic                  sel_id, sel_uc, sel_bsr, sel_isc, sel_c0, sel_c1;

    always_ff @(posedge i_tck) begin
        rst_t1 <= i_rst;
        rst_t2 <= rst_t1;
    end

    always_comb begin
        case (state)
            TS_RESET:  next_state = i_tms ? TS_RESET  : TS_IDLE;
            TS_IDLE:   next_state = i_tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: next_state = i_tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: next_state = i_tms ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  next_state = i_tms ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: next_state = i_tms ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: next_state = i_tms ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: next_state = i_tms ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: next_state = i_tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: next_state = i_tms ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: next_state = i_tms ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  next_state = i_tms ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: next_state = i_tms ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: next_state = i_tms ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: next_state = i_tms ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: next_state = i_tms ? TS_SEL_DR : TS_IDLE;
            default:   next_state = TS_RESET;
        endcase
    end

    always_ff @(posedge i_tck) begin
        state <= rst_t2 ? TS_RESET : next_state;
    end

    // Instruction decode; anything unknown falls back to bypass
    assign sel_id  = (ir == IDCODE_INSTR);
    assign sel_uc  = (ir == USERCODE_INSTR);
    assign sel_bsr = (ir == EXTEST_INSTR) || (ir == SAMPLE_INSTR);
    assign sel_isc = (ir == ISC_PROGRAM_INSTR);
    assign sel_c0  = (ir == USER_CHAIN_ZERO_INSTR);
    assign sel_c1  = (ir == USER_CHAIN_ONE_INSTR);

    // Exposure to the user chains in the array
    assign o_usr_state  = state;
    assign o_usr_tms    = i_tms;
    assign o_usr_tdi    = i_tdi;
    assign o_chain0_sel = sel_c0;
    assign o_chain1_sel = sel_c1;

    // Boundary capture vector: input, output, enable cells per pin
    for (genvar k = 0; k < N_IO; k++) begin : g_cap
        assign cap_raw[k*CELLS_PER_IO+CELL_IN]  = i_io_in[k];
        assign cap_raw[k*CELLS_PER_IO+CELL_OUT] = i_core_out[k];
        assign cap_raw[k*CELLS_PER_IO+CELL_OE]  = i_core_oe[k];
    end

    always_ff @(posedge i_tck) begin
        cap_s1 <= cap_raw;
        cap_s2 <= cap_s1;
    end

    // Shift registers on the rising edge
    always_comb begin
        next_ir_sh   = ir_sh;
        next_byp     = byp;
        next_word_sh = word_sh;
        next_isc_sh  = isc_sh;
        next_bsr_sh  = bsr_sh;
        if (state == TS_CAP_IR) begin
            next_ir_sh = IR_CAPTURE;
        end else if (state == TS_SH_IR) begin
            next_ir_sh = {i_tdi, ir_sh[IR_W-1:1]};
        end
        if (state == TS_CAP_DR) begin
            next_byp     = 1'b0;
            next_word_sh = sel_id ? {ID_VERSION, ID_PART, ID_MFR, 1'b1}
                                  : USERCODE;
            next_isc_sh  = {wr_addr, wr_data};
            next_bsr_sh  = cap_s2;
        end else if (state == TS_SH_DR) begin
            next_byp = i_tdi;
            if (sel_id || sel_uc) begin
                next_word_sh = {i_tdi, word_sh[ID_W-1:1]};
            end
            if (sel_isc) begin
                next_isc_sh = {i_tdi, isc_sh[ISC_W-1:1]};
            end
            if (sel_bsr) begin
                next_bsr_sh = {i_tdi, bsr_sh[BSR_LEN-1:1]};
            end
        end
    end

    always_ff @(posedge i_tck) begin
        ir_sh   <= next_ir_sh;
        byp     <= next_byp;
        word_sh <= next_word_sh;
        isc_sh  <= next_isc_sh;
        bsr_sh  <= next_bsr_sh;
    end

    // Output mux for the data path
    always_comb begin
        if (sel_c0) begin
            sel_dr_tdo = i_chain0_tdo;
        end else if (sel_c1) begin
            sel_dr_tdo = i_chain1_tdo;
        end else if (sel_id || sel_uc) begin
            sel_dr_tdo = word_sh[0];
        end else if (sel_bsr) begin
            sel_dr_tdo = bsr_sh[0];
        end else if (sel_isc) begin
            sel_dr_tdo = isc_sh[0];
        end else begin
            sel_dr_tdo = byp;
        end
    end

    // Update and output registers on the falling edge
    always_comb begin
        next_ir         = ir;
        next_isp_req    = isp_req;
        next_bsr_upd    = bsr_upd;
        next_wr_addr    = wr_addr;
        next_wr_data    = wr_data;
        next_wr_tgl     = wr_tgl;
        next_tdo        = 1'b0;
        next_tdo_oe     = (state == TS_SH_IR) || (state == TS_SH_DR);
        if (rst_t2 || state == TS_RESET) begin
            next_ir = IDCODE_INSTR;
        end else if (state == TS_UPD_IR) begin
            next_ir = ir_sh;
            if (ir_sh == ISC_ENABLE_INSTR) begin
                next_isp_req = 1'b1;
            end else if (ir_sh == ISC_DISABLE_INSTR) begin
                next_isp_req = 1'b0;
            end
        end
        if (rst_t2) begin
            next_isp_req = 1'b0;
            next_bsr_upd = '0;
            next_wr_tgl  = 1'b0;
        end else if (state == TS_UPD_DR && sel_bsr) begin
            next_bsr_upd = bsr_sh;
        end else if (state == TS_UPD_DR && sel_isc && isp_req) begin
            next_wr_addr = isc_sh[ISC_W-1:CFG_DW];
            next_wr_data = isc_sh[CFG_DW-1:0];
            next_wr_tgl  = ~wr_tgl;
        end
        if (state == TS_SH_IR) begin
            next_tdo = ir_sh[0];
        end else if (state == TS_SH_DR) begin
            next_tdo = sel_dr_tdo;
        end
        next_mode_highz = (next_ir == HIGHZ_INSTR);
        next_mode_hold  = (next_ir == CLAMP_INSTR) || (next_ir == EXTEST_INSTR);
    end

    always_ff @(negedge i_tck) begin
        ir         <= next_ir;
        isp_req    <= next_isp_req;
        bsr_upd    <= next_bsr_upd;
        wr_addr    <= next_wr_addr;
        wr_data    <= next_wr_data;
        wr_tgl     <= next_wr_tgl;
        mode_highz <= next_mode_highz;
        mode_hold  <= next_mode_hold;
        o_tdo      <= next_tdo;
        o_tdo_oe   <= next_tdo_oe;
    end

    // ---------------- System clock domain ----------------
    typedef enum logic [1:0] {SS_LOAD, SS_LOAD_END, SS_USER, SS_ISP} jtp_sys_state_t;

    jtp_sys_state_t      sstate, next_sstate;
    logic [3:0]          lvl_s1, lvl_s2;
    logic                tgl_s3;
    logic [BSR_LEN-1:0]  bsr_s1, bsr_s2;
    logic [CFG_AW-1:0]   ld_addr, next_ld_addr, next_cfg_addr, mem_waddr, next_mem_waddr;
    logic [CFG_DW-1:0]   mem_rdata, mem_wdata, next_mem_wdata;
    logic                next_cfg_we, mem_we, next_mem_we;
    logic                programming_complete_bit, next_done;
    logic                isp_lvl, hold_lvl, highz_lvl, wr_evt, user_mode;
    logic [N_IO-1:0]     next_io_out, next_io_oe, next_io_pullup;

    always_ff @(posedge i_clk_sys) begin
        lvl_s1 <= {wr_tgl, mode_hold, mode_highz, isp_req};
        lvl_s2 <= lvl_s1;
        tgl_s3 <= lvl_s2[3];
        bsr_s1 <= bsr_upd;
        bsr_s2 <= bsr_s1;
    end

    assign isp_lvl   = lvl_s2[0];
    assign highz_lvl = lvl_s2[1];
    assign hold_lvl  = lvl_s2[2];
    assign wr_evt    = lvl_s2[3] ^ tgl_s3;
    assign user_mode = (next_sstate == SS_USER);

    jtp_configuration_flash_array #(
        .AW   (CFG_AW),
        .DW   (CFG_DW),
        .INIT (FLASH_INIT)
    ) configuration_flash_array (
        .i_clk_sys (i_clk_sys),
        .i_we      (mem_we),
        .i_waddr   (mem_waddr),
        .i_wdata   (mem_wdata),
        .i_raddr   (ld_addr),
        .o_rdata   (mem_rdata)
    );

    always_comb begin
        next_sstate    = sstate;
        next_ld_addr   = ld_addr;
        next_cfg_we    = 1'b0;
        next_cfg_addr  = ld_addr;
        next_mem_we    = 1'b0;
        next_mem_waddr = mem_waddr;
        next_mem_wdata = mem_wdata;
        next_done      = programming_complete_bit;
        if (o_cfg_we && o_cfg_addr == DONE_ADDR) begin
            next_done = mem_rdata[DONE_BIT];
        end
        case (sstate)
            SS_LOAD: begin
                next_cfg_we = 1'b1;
                if (ld_addr == DONE_ADDR) begin
                    next_sstate = SS_LOAD_END;
                end else begin
                    next_ld_addr = ld_addr + 1'b1;
                end
            end
            SS_LOAD_END: begin
                next_sstate = SS_USER;
            end
            SS_USER: begin
                if (isp_lvl) begin
                    next_sstate    = SS_ISP;
                    next_mem_we    = 1'b1;
                    next_mem_waddr = DONE_ADDR;
                    next_mem_wdata = '0;
                    next_done      = 1'b0;
                end
            end
            SS_ISP: begin
                if (wr_evt) begin
                    next_mem_we    = 1'b1;
                    next_mem_waddr = wr_addr;
                    next_mem_wdata = wr_data;
                    if (wr_addr == DONE_ADDR) begin
                        next_done = wr_data[DONE_BIT];
                    end
                end else if (!isp_lvl) begin
                    next_sstate  = SS_LOAD;
                    next_ld_addr = '0;
                end
            end
            default: begin
                next_sstate = SS_LOAD;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sstate                   <= SS_LOAD;
            ld_addr                  <= '0;
            o_cfg_we                 <= 1'b0;
            o_cfg_addr               <= '0;
            mem_we                   <= 1'b0;
            mem_waddr                <= '0;
            mem_wdata                <= '0;
            programming_complete_bit <= 1'b0;
        end else begin
            sstate                   <= next_sstate;
            ld_addr                  <= next_ld_addr;
            o_cfg_we                 <= next_cfg_we;
            o_cfg_addr               <= next_cfg_addr;
            mem_we                   <= next_mem_we;
            mem_waddr                <= next_mem_waddr;
            mem_wdata                <= next_mem_wdata;
            programming_complete_bit <= next_done;
        end
    end

    assign o_cfg_data    = mem_rdata;
    assign o_config_done = (sstate == SS_USER);
    assign o_hv_pump_en  = mem_we;

    // Pin control per pin
    for (genvar k = 0; k < N_IO; k++) begin : g_pin
        assign next_io_pullup[k] = user_mode ? i_core_pullup[k] : 1'b1;
        assign next_io_oe[k]     = (!user_mode || !programming_complete_bit) ? 1'b0 :
                                   highz_lvl ? 1'b0 :
                                   hold_lvl  ? bsr_s2[k*CELLS_PER_IO+CELL_OE] :
                                   i_core_oe[k];
        assign next_io_out[k]    = hold_lvl ? bsr_s2[k*CELLS_PER_IO+CELL_OUT] : i_core_out[k];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_io_out    <= '0;
            o_io_oe     <= '0;
            o_io_pullup <= '1;
        end else begin
            o_io_out    <= next_io_out;
            o_io_oe     <= next_io_oe;
            o_io_pullup <= next_io_pullup;
        end
    end

endmodule // jtp_tap_isp

// ---- jtp_user_chains.sv ----
// Purpose: Model of the two user scan chains built in the logic array
// Assumes: Chains shift on rising test clock while the port is in Shift-DR
// Notes:   Unselected chain shows the inverse of its last bit
`timescale 1ns/1ps
module jtp_user_chains
    import jtp_pkg::*;
#(
    parameter int L0 = 5,
    parameter int L1 = 7
) (
    input  wire logic           i_tck,
    input  wire logic           i_rst,
    input  wire jtp_tap_state_t i_state,
    input  wire logic           i_tdi,
    input  wire logic           i_sel0,
    input  wire logic           i_sel1,
    output logic                o_tdo0,
    output logic                o_tdo1
);
    logic [L0-1:0] q0;
    logic [L1-1:0] q1;
    always_ff @(posedge i_tck) begin
        if (i_rst) begin
            q0 <= '0;
            q1 <= '0;
        end else if (i_state == TS_SH_DR) begin
            if (i_sel0) q0 <= {i_tdi, q0[L0-1:1]};
            if (i_sel1) q1 <= {i_tdi, q1[L1-1:1]};
        end
    end
    assign o_tdo0 = i_sel0 ? q0[0] : ~q0[0];
    assign o_tdo1 = i_sel1 ? q1[0] : ~q1[0];
endmodule // jtp_user_chains

// ---- jtp_tap_isp_monitor.sv ----
// Purpose: Port checker of the scan and programming port
// Assumes: Bound to the top module
// Notes:   Two clock domains, each property names its own
`timescale 1ns/1ps
module jtp_tap_isp_monitor
    import jtp_pkg::*;
#(
    parameter int N_IO = 80
) (
    input wire logic              i_clk_sys,
    input wire logic              i_rst,
    input wire logic              i_tck,
    input wire logic              i_tms,
    input wire logic              o_tdo_oe,
    input wire jtp_tap_state_t    o_usr_state,
    input wire logic              o_chain0_sel,
    input wire logic              o_chain1_sel,
    input wire logic [N_IO-1:0]   o_io_oe,
    input wire logic [N_IO-1:0]   o_io_pullup,
    input wire logic              o_cfg_we,
    input wire logic [CFG_AW-1:0] o_cfg_addr,
    input wire logic              o_config_done,
    input wire logic              o_hv_pump_en
);
    property p_oe_safe;
        @(posedge i_clk_sys) disable iff (i_rst) !o_config_done |-> o_io_oe == '0;
    endproperty
    a_oe_safe: assert property (p_oe_safe) else $error("pin driven before done");
    property p_load_pullup;
        @(posedge i_clk_sys) disable iff (i_rst) !o_config_done |-> &o_io_pullup;
    endproperty
    a_load_pullup: assert property (p_load_pullup) else $error("pull-up off in load");
    property p_load_walk;
        @(posedge i_clk_sys) disable iff (i_rst) o_cfg_we && o_cfg_addr != 6'h3f
            |=> o_cfg_we && o_cfg_addr == $past(o_cfg_addr) + 6'h01;
    endproperty
    a_load_walk: assert property (p_load_walk) else $error("load walk broken");
    property p_we_not_user;
        @(posedge i_clk_sys) disable iff (i_rst) o_cfg_we |-> !o_config_done;
    endproperty
    a_we_not_user: assert property (p_we_not_user) else $error("load in user mode");
    property p_pump_pulse;
        @(posedge i_clk_sys) disable iff (i_rst) $rose(o_hv_pump_en) |=> !o_hv_pump_en;
    endproperty
    a_pump_pulse: assert property (p_pump_pulse) else $error("pump pulse too long");
    property p_tdo_oe;
        @(posedge i_tck) disable iff (i_rst)
            o_tdo_oe == (o_usr_state == TS_SH_DR || o_usr_state == TS_SH_IR);
    endproperty
    a_tdo_oe: assert property (p_tdo_oe) else $error("tdo enable off shift");
    property p_tlr_hold;
        @(posedge i_tck) disable iff (i_rst) o_usr_state == TS_RESET && i_tms
            |=> o_usr_state == TS_RESET;
    endproperty
    a_tlr_hold: assert property (p_tlr_hold) else $error("left reset state");
    property p_shift_hold;
        @(posedge i_tck) disable iff (i_rst) o_usr_state == TS_SH_DR && !i_tms
            |=> o_usr_state == TS_SH_DR;
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("left shift state");
    property p_chain_excl;
        @(posedge i_tck) disable iff (i_rst) !(o_chain0_sel && o_chain1_sel);
    endproperty
    a_chain_excl: assert property (p_chain_excl) else $error("both chains selected");
    c_load: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_cfg_we);
    c_pump: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_hv_pump_en);
    c_chain1: cover property (@(posedge i_tck) disable iff (i_rst) o_chain1_sel);
endmodule // jtp_tap_isp_monitor

// ---- testbench.sv ----
// Purpose: Self-checking bench of the scan and programming port
// Assumes: Test clock made per frame at 6 ns, still between frames
// Notes:   Smallest boundary variant
`timescale 1ns/1ps
module testbench;
    import jtp_pkg::*;
    localparam int N = BSR_LEN_A / CELLS_PER_IO;
    logic           clk = 1'b0, rst = 1'b1, tck = 1'b0, tms = 1'b1, tdi = 1'b0;
    logic           tdo, sel0, sel1, ctdo0, ctdo1, utdi, utms, cfg_we, done, pump;
    logic [N-1:0]   io_out, io_oe, io_pu;
    logic [N-1:0]   c_out = {10{8'h3c}}, c_oe = {10{8'hff}}, c_pu = {10{8'h96}};
    logic [5:0]     cfg_addr;
    logic [15:0]    cfg_data, ld_data = 16'h0000;
    jtp_tap_state_t ust;
    int             n_mismatch = 0, total_checks = 0, n_pump = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (pump === 1'b1) n_pump++;
    always @(posedge clk) if (cfg_we === 1'b1 && cfg_addr === 6'h05) ld_data <= cfg_data;
    jtp_tap_isp #(.BSR_LEN(BSR_LEN_A), .ID_VERSION(4'h3), .ID_PART(16'hc3a5),
        .ID_MFR(11'h155)) u_dut (  // Arbitrary identity values
        .i_clk_sys(clk), .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(), .o_usr_state(ust), .o_usr_tms(utms), .o_usr_tdi(utdi),
        .o_chain0_sel(sel0), .o_chain1_sel(sel1), .i_chain0_tdo(ctdo0),
        .i_chain1_tdo(ctdo1), .i_io_in({N{1'b1}}), .o_io_out(io_out), .o_io_oe(io_oe),
        .o_io_pullup(io_pu), .i_core_out(c_out), .i_core_oe(c_oe), .i_core_pullup(c_pu),
        .o_cfg_we(cfg_we), .o_cfg_addr(cfg_addr), .o_cfg_data(cfg_data),
        .o_config_done(done), .o_hv_pump_en(pump));
    jtp_user_chains #(.L0(5), .L1(7)) u_chains (.i_tck(tck), .i_rst(rst), .i_state(ust),
        .i_tdi(utdi), .i_sel0(sel0), .i_sel1(sel1), .o_tdo0(ctdo0), .o_tdo1(ctdo1));
    task automatic check(string nm, logic [N-1:0] seen, logic [N-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tclk(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3 tck = 1'b1;
        q = tdo;
        #3 tck = 1'b0;
    endtask
    // From Idle: one scan of n bits, back to Idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        tclk(1'b1, 1'b0, q);
        if (ir) tclk(1'b1, 1'b0, q);
        tclk(1'b0, 1'b0, q);
        tclk(1'b0, 1'b0, q);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            tclk(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tclk(1'b1, 1'b0, q);
        tclk(1'b0, 1'b0, q);
    endtask
    task automatic load_ir(input logic [9:0] op);
        logic [31:0] d;
        scan(1'b1, 10, {22'h0, op}, d);
        check("ir capture", d, IR_CAPTURE);
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        while (done !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        check("config done", done, 1'b1);
    endtask
    task automatic t_ids;
        logic [31:0] d;
        scan(1'b0, 32, 32'h0, d);
        check("idcode", d, {4'h3, 16'hc3a5, 11'h155, 1'b1});
        load_ir(USERCODE_INSTR);
        scan(1'b0, 32, 32'h0, d);
        check("usercode", d, 32'hffffffff);
        load_ir(BYPASS_INSTR);
        scan(1'b0, 8, 32'hb4, d);
        check("bypass", d, 32'h68);
    endtask
    task automatic t_chains;
        logic [31:0] d;
        load_ir(USER_CHAIN_ZERO_INSTR);
        check("sel", {sel0, sel1}, 2'b10);
        scan(1'b0, 12, 32'h9d3, d);
        check("chain0", d, (32'h9d3 << 5) & 32'hfff);
        check("state", ust, TS_IDLE);
        check("usr tms", utms, tms);
        load_ir(USER_CHAIN_ONE_INSTR);
        check("sel", {sel0, sel1}, 2'b01);
        scan(1'b0, 12, 32'h5a7, d);
        check("chain1", d, (32'h5a7 << 7) & 32'hfff);
    endtask
    task automatic t_isp;
        logic [31:0] d;
        check("oe blank part", io_oe, '0);
        load_ir(ISC_ENABLE_INSTR);
        repeat (10) @(negedge clk);
        check("isp oe", io_oe, '0);
        check("isp pullup", io_pu, {N{1'b1}});
        load_ir(ISC_PROGRAM_INSTR);
        scan(1'b0, ISC_W, {10'h0, 6'h05, 16'h1234}, d);
        scan(1'b0, ISC_W, {10'h0, DONE_ADDR, 16'h0001}, d);
        repeat (10) @(negedge clk);
        check("pump count", n_pump, 3);
        load_ir(ISC_DISABLE_INSTR);
        repeat (8) @(negedge clk);
        wait_done();
        check("reload word", ld_data, 16'h1234);
        check("user oe", io_oe, c_oe);
        check("user out", io_out, c_out);
        load_ir(HIGHZ_INSTR);
        repeat (10) @(negedge clk);
        check("highz oe", io_oe, '0);
        check("highz pullup", io_pu, c_pu);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    initial begin
        logic q;
        repeat (5) tclk(1'b1, 1'b0, q);
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (3) tclk(1'b1, 1'b0, q);
        tclk(1'b0, 1'b0, q);
        wait_done();
        t_ids();
        t_chains();
        t_isp();
        results();
    end
endmodule // testbench
bind jtp_tap_isp jtp_tap_isp_monitor #(.N_IO(N_IO)) u_mon (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms), .o_tdo_oe(o_tdo_oe),
    .o_usr_state(o_usr_state), .o_chain0_sel(o_chain0_sel), .o_chain1_sel(o_chain1_sel),
    .o_io_oe(o_io_oe), .o_io_pullup(o_io_pullup), .o_cfg_we(o_cfg_we),
    .o_cfg_addr(o_cfg_addr), .o_config_done(o_config_done), .o_hv_pump_en(o_hv_pump_en));
